//--- design/radio_bitstream_encoder.sv
// Bit-stream encoder between the framing unit and the modulator/demodulator.
// Assumes one clock, synchronous inputs and a classic Wishbone master.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module radio_bitstream_encoder (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Transmit data from framing unit
   input wire logic tx_bit_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Transmit symbols to modulator
   output logic tx_sym_o,
   output logic tx_sym_valid_o,
   input wire logic tx_sym_ready_i,
   // Receive symbols from demodulator
   input wire logic rx_sym_i,
   input wire logic rx_sym_valid_i,
   output logic rx_sym_ready_o,
   // Receive data to framing unit
   output logic rx_bit_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i
);
   logic [radio_bitstream_encoder_pkg::CFG_WIDTH-1:0] cfg_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic manch_err_r;
   logic [radio_bitstream_encoder_pkg::CNT_WIDTH-1:0] tx_cnt_r;
   logic [radio_bitstream_encoder_pkg::CNT_WIDTH-1:0] rx_cnt_r;

   wire cfg_inv = cfg_r[radio_bitstream_encoder_pkg::CFG_INVERT];
   wire cfg_diff = cfg_r[radio_bitstream_encoder_pkg::CFG_DIFF];
   wire cfg_manch = cfg_r[radio_bitstream_encoder_pkg::CFG_MANCH];
   wire cfg_shape = cfg_r[radio_bitstream_encoder_pkg::CFG_SHAPE];

   // ---------------- Register bus ----------------
   wire bus_req = cyc_i && stb_i && !ack_r;
   wire [7:0] reg_adr = {adr_i[7:2], 2'b00};
   wire hit_cfg = (reg_adr == radio_bitstream_encoder_pkg::ADDR_CFG);
   wire hit_stat = (reg_adr == radio_bitstream_encoder_pkg::ADDR_STAT);
   wire hit_tx_cnt = (reg_adr == radio_bitstream_encoder_pkg::ADDR_TX_CNT);
   wire hit_rx_cnt = (reg_adr == radio_bitstream_encoder_pkg::ADDR_RX_CNT);
   wire in_window = (adr_i[31:8] == 24'h000000);
   wire wr_cfg = bus_req && we_i && sel_i[0] && in_window && hit_cfg;
   wire wr_stat = bus_req && we_i && sel_i[0] && in_window && hit_stat;
   wire clr_manch_err = wr_stat && dat_i[radio_bitstream_encoder_pkg::STAT_MANCH_ERR];

   logic tx_buf_valid;
   logic rx_buf_valid;
   radio_bitstream_encoder_pkg::half_t tx_half_r;
   radio_bitstream_encoder_pkg::half_t rx_half_r;

   wire [31:0] stat_word = {27'h0000000,
                            (rx_half_r == radio_bitstream_encoder_pkg::HALF_SECOND),
                            (tx_half_r == radio_bitstream_encoder_pkg::HALF_SECOND),
                            manch_err_r, rx_buf_valid, tx_buf_valid};
   wire [31:0] rd_mux = !in_window ? 32'h00000000 :
                        hit_cfg ? {28'h0000000, cfg_r} :
                        hit_stat ? stat_word :
                        hit_tx_cnt ? {16'h0000, tx_cnt_r} :
                        hit_rx_cnt ? {16'h0000, rx_cnt_r} : 32'h00000000;

   // Ack comes one cycle after the request and blocks an immediate repeat
   assign ack_o = ack_r;
   assign dat_o = rdata_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r <= bus_req;
         rdata_r <= bus_req ? rd_mux : 32'h00000000;
      end
   end

   // One register sets the transforms of both paths
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= radio_bitstream_encoder_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         cfg_r <= dat_i[radio_bitstream_encoder_pkg::CFG_WIDTH-1:0];
      end
   end

   // ---------------- Transmit path ----------------
   // Order: shape, differential, invert, Manchester
   logic tx_buf_ready;
   logic tx_diff_r;
   logic tx_scr_bit;
   radio_bitstream_encoder_pkg::half_t tx_half_nxt;
   wire tx_half2 = (tx_half_r == radio_bitstream_encoder_pkg::HALF_SECOND);
   // Data bit taken only when its last symbol enters the buffer
   wire tx_take_ok = !cfg_manch || tx_half2;
   assign tx_ready_o = tx_buf_ready && tx_take_ok;
   wire tx_push = tx_valid_i && tx_buf_ready;
   wire tx_fire = tx_push && tx_take_ok;

   shape_scrambler #(
      .DESCRAMBLE(1'b0)
   ) u_tx_shape (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .data_i(tx_bit_i),
      .step_i(tx_fire && cfg_shape),
      .data_o(tx_scr_bit)
   );

   wire tx_s1 = cfg_shape ? tx_scr_bit : tx_bit_i;
   wire tx_s2 = cfg_diff ? (tx_diff_r ^ tx_s1) : tx_s1;
   wire tx_s3 = tx_s2 ^ cfg_inv;
   // First half carries the bit, second its complement
   wire tx_sym = (cfg_manch && tx_half2) ? ~tx_s3 : tx_s3;

   // With Manchester on, phase advances on every symbol that enters the buffer
   always_comb begin
      tx_half_nxt = tx_half_r;
      if (!cfg_manch) begin
         tx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
      end else if (tx_push) begin
         case (tx_half_r)
            radio_bitstream_encoder_pkg::HALF_FIRST: begin
               tx_half_nxt = radio_bitstream_encoder_pkg::HALF_SECOND;
            end
            radio_bitstream_encoder_pkg::HALF_SECOND: begin
               tx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
            end
            default: begin
               tx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_half_r <= radio_bitstream_encoder_pkg::HALF_FIRST;
      end else begin
         tx_half_r <= tx_half_nxt;
      end
   end

   // Last line level before inversion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_diff_r <= 1'b0;
      end else if (tx_fire && cfg_diff) begin
         tx_diff_r <= tx_s2;
      end
   end

   stream_buffer2 u_tx_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(tx_sym),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_buf_ready),
      .out_data_o(tx_sym_o),
      .out_valid_o(tx_buf_valid),
      .out_ready_i(tx_sym_ready_i)
   );
   assign tx_sym_valid_o = tx_buf_valid;

   // ---------------- Receive path ----------------
   // Order: Manchester, invert, differential, shape
   logic rx_buf_ready;
   logic rx_first_r;
   logic rx_diff_r;
   logic rx_descr_bit;
   radio_bitstream_encoder_pkg::half_t rx_half_nxt;
   wire rx_half2 = (rx_half_r == radio_bitstream_encoder_pkg::HALF_SECOND);
   // First half is only stored, so it needs no room downstream
   wire rx_store = cfg_manch && !rx_half2;
   assign rx_sym_ready_o = rx_store || rx_buf_ready;
   wire rx_take = rx_sym_valid_i && rx_sym_ready_o;
   wire rx_fire = rx_take && !rx_store;
   wire rx_manch_bad = cfg_manch && rx_fire && (rx_first_r == rx_sym_i);

   wire rx_d1 = cfg_manch ? rx_first_r : rx_sym_i;
   wire rx_d2 = rx_d1 ^ cfg_inv;
   // Level change decoding is blind to polarity
   wire rx_d3 = cfg_diff ? (rx_d2 ^ rx_diff_r) : rx_d2;

   shape_scrambler #(
      .DESCRAMBLE(1'b1)
   ) u_rx_shape (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .data_i(rx_d3),
      .step_i(rx_fire && cfg_shape),
      .data_o(rx_descr_bit)
   );

   wire rx_d4 = cfg_shape ? rx_descr_bit : rx_d3;

   // Pair alignment restarts at reset or when Manchester is switched on
   always_comb begin
      rx_half_nxt = rx_half_r;
      if (!cfg_manch) begin
         rx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
      end else if (rx_take) begin
         case (rx_half_r)
            radio_bitstream_encoder_pkg::HALF_FIRST: begin
               rx_half_nxt = radio_bitstream_encoder_pkg::HALF_SECOND;
            end
            radio_bitstream_encoder_pkg::HALF_SECOND: begin
               rx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
            end
            default: begin
               rx_half_nxt = radio_bitstream_encoder_pkg::HALF_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_half_r <= radio_bitstream_encoder_pkg::HALF_FIRST;
      end else begin
         rx_half_r <= rx_half_nxt;
      end
   end

   // First half waits here for its partner
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_first_r <= 1'b0;
      end else if (rx_take && rx_store) begin
         rx_first_r <= rx_sym_i;
      end
   end

   // Previous line level after inversion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_diff_r <= 1'b0;
      end else if (rx_fire && cfg_diff) begin
         rx_diff_r <= rx_d2;
      end
   end

   stream_buffer2 u_rx_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(rx_d4),
      .in_valid_i(rx_sym_valid_i && !rx_store),
      .in_ready_o(rx_buf_ready),
      .out_data_o(rx_bit_o),
      .out_valid_o(rx_buf_valid),
      .out_ready_i(rx_ready_i)
   );
   assign rx_valid_o = rx_buf_valid;

   // ---------------- Status and counters ----------------
   // A violation in the clearing cycle stays set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         manch_err_r <= 1'b0;
      end else begin
         manch_err_r <= rx_manch_bad || (manch_err_r && !clr_manch_err);
      end
   end

   // Counters wrap at their width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_cnt_r <= radio_bitstream_encoder_pkg::CNT_RESET;
      end else if (tx_fire) begin
         tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cnt_r <= radio_bitstream_encoder_pkg::CNT_RESET;
      end else if (rx_fire) begin
         rx_cnt_r <= rx_cnt_r + 16'h0001;
      end
   end
endmodule
`default_nettype wire

//--- design/radio_bitstream_encoder_pkg.sv
// Constants shared by the bit-stream encoder and its helper modules.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package radio_bitstream_encoder_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_TX_CNT = 8'h08;
   localparam logic [7:0] ADDR_RX_CNT = 8'h0C;
   // Configuration field positions
   localparam int CFG_INVERT = 0;
   localparam int CFG_DIFF = 1;
   localparam int CFG_MANCH = 2;
   localparam int CFG_SHAPE = 3;
   localparam int CFG_WIDTH = 4;
   localparam logic [3:0] CFG_RESET = 4'h0;
   // Status field positions
   localparam int STAT_TX_PEND = 0;
   localparam int STAT_RX_PEND = 1;
   localparam int STAT_MANCH_ERR = 2;
   localparam int STAT_TX_HALF = 3;
   localparam int STAT_RX_HALF = 4;
   // Counter width and reset value
   localparam int CNT_WIDTH = 16;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   // Self-synchronising shaper: x^17 + x^12 + 1
   localparam int SHAPE_LEN = 17;
   localparam int SHAPE_TAP_A = 11;
   localparam int SHAPE_TAP_B = 16;
   localparam logic [16:0] SHAPE_SEED = 17'h1FFFF;
   // Two-entry buffer
   localparam int BUF_DEPTH = 2;
   // Manchester half-bit phase, one-hot
   typedef enum logic [1:0] {
      HALF_FIRST = 2'b01,
      HALF_SECOND = 2'b10
   } half_t;
endpackage

//--- design/stream_buffer2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module stream_buffer2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [1:0] mem_r;
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;
   logic [1:0] count_nxt;

   assign in_ready_o = (count_r != 2'(radio_bitstream_encoder_pkg::BUF_DEPTH));
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_r <= 2'h0;
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

//--- design/shape_scrambler.sv
// Self-synchronising scrambler or descrambler, x^17 + x^12 + 1.
// Assumes step_i pulses once per data bit consumed.
`timescale 1ns/1ps
`default_nettype none
module shape_scrambler #(
   parameter bit DESCRAMBLE = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic data_i,
   input wire logic step_i,
   output logic data_o
);
   logic [radio_bitstream_encoder_pkg::SHAPE_LEN-1:0] sr_r;
   logic fb;
   logic shift_bit;

   assign fb = sr_r[radio_bitstream_encoder_pkg::SHAPE_TAP_A]
             ^ sr_r[radio_bitstream_encoder_pkg::SHAPE_TAP_B];
   assign data_o = data_i ^ fb;
   // Descrambler shifts the line bit so it relocks after any sr_r error
   assign shift_bit = DESCRAMBLE ? data_i : data_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sr_r <= radio_bitstream_encoder_pkg::SHAPE_SEED;
      end else if (step_i) begin
         sr_r <= {sr_r[radio_bitstream_encoder_pkg::SHAPE_LEN-2:0], shift_bit};
      end
   end
endmodule
`default_nettype wire

//--- dv/radio_bitstream_encoder_props.sv
// Port-level assertions for the bit-stream encoder.
// Assumes one clock, bound onto the encoder's top module.
`timescale 1ns/1ps
`default_nettype none
module radio_bitstream_encoder_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic tx_bit_i,
   input wire logic tx_valid_i,
   input wire logic tx_ready_o,
   input wire logic tx_sym_o,
   input wire logic tx_sym_valid_o,
   input wire logic tx_sym_ready_i,
   input wire logic rx_sym_i,
   input wire logic rx_sym_valid_i,
   input wire logic rx_sym_ready_o,
   input wire logic rx_bit_o,
   input wire logic rx_valid_o,
   input wire logic rx_ready_i
);
   logic [3:0] cfg_r;
   wire logic cfg_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[31:2] == 30'h0;
   wire logic tx_push = tx_valid_i && tx_ready_o && !tx_sym_valid_o;
   wire logic rx_push = rx_sym_valid_i && rx_sym_ready_o && !rx_valid_o;
   // Shadow of the configuration so path checks know the active transforms
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= 4'h0;
      end else if (cfg_wr) begin
         cfg_r <= dat_i[3:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_rdata_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_tx_holds: assert property (tx_sym_valid_o && !tx_sym_ready_i |=> tx_sym_valid_o && $stable(tx_sym_o))
      else $error("tx symbol lost under stall");
   a_rx_holds: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_bit_o))
      else $error("rx bit lost under stall");
   a_tx_plain: assert property (cfg_r[3:1] == 3'h0 && tx_push |=> tx_sym_valid_o && tx_sym_o == $past(tx_bit_i ^ cfg_r[0]))
      else $error("tx plain path wrong");
   a_rx_plain: assert property (cfg_r[3:1] == 3'h0 && rx_push |=> rx_valid_o && rx_bit_o == $past(rx_sym_i ^ cfg_r[0]))
      else $error("rx plain path wrong");
   a_manch_halves: assert property (cfg_r[2] && tx_valid_i && tx_ready_o |=> !tx_ready_o)
      else $error("data taken on first half");
   a_shape_rate: assert property (cfg_r == 4'h8 && tx_push |=> tx_sym_valid_o)
      else $error("shaping delayed a symbol");
endmodule
bind radio_bitstream_encoder radio_bitstream_encoder_props radio_bitstream_encoder_props_i (.*);
`default_nettype wire

//--- dv/line_peer.sv
// Modulator and demodulator stand-in: loops sent symbols back to receive.
// Assumes the encoder's clock and reset; the bench steers stall, pace and polarity.
`timescale 1ns/1ps
`default_nettype none
module line_peer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   input wire logic slow_i,
   input wire logic flip_i,
   input wire logic tx_sym_i,
   input wire logic tx_sym_valid_i,
   output logic tx_sym_ready_o,
   output logic rx_sym_o,
   output logic rx_sym_valid_o,
   input wire logic rx_sym_ready_i
);
   logic q[$];
   logic tick_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         q.delete();
         tick_r <= 1'b0;
         tx_sym_ready_o <= 1'b0;
         rx_sym_valid_o <= 1'b0;
         rx_sym_o <= 1'b0;
      end else begin
         if (tx_sym_valid_i && tx_sym_ready_o) q.push_back(tx_sym_i);
         if (rx_sym_valid_o && rx_sym_ready_i) void'(q.pop_front());
         tick_r <= !tick_r;
         tx_sym_ready_o <= !stall_i && !(slow_i && tick_r);
         rx_sym_valid_o <= q.size() > 0;
         // Idle line toggles so no stale level looks like data
         rx_sym_o <= (q.size() > 0) ? q[0] ^ flip_i : !rx_sym_o;
      end
   end
endmodule
`default_nettype wire

//--- dv/test_radio_bitstream_encoder.sv
// Self-checking bench for the bit-stream encoder over a looped-back line.
// Assumes the line peer model and the bound assertion checker.
`timescale 1ns/1ps
`default_nettype none
module test_radio_bitstream_encoder;
   localparam logic [31:0] PAT = 32'hC3A5_0F96;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
   logic [3:0] sel_i = 4'h0;
   logic tx_bit_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b1, stall = 1'b0, slow = 1'b0;
   logic flip = 1'b0, ack_o, tx_ready_o, tx_sym_o, tx_sym_valid_o, tx_sym_ready_i;
   logic rx_sym_i, rx_sym_valid_i, rx_sym_ready_o, rx_bit_o, rx_valid_o;
   logic symq[$], bitq[$];
   int errors = 0, num_checks = 0;
   always #10 clk_i = ~clk_i;
   radio_bitstream_encoder radio_bitstream_encoder_i (.*);
   line_peer line_peer_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
      .flip_i(flip), .tx_sym_i(tx_sym_o), .tx_sym_valid_i(tx_sym_valid_o),
      .tx_sym_ready_o(tx_sym_ready_i), .rx_sym_o(rx_sym_i), .rx_sym_valid_o(rx_sym_valid_i),
      .rx_sym_ready_i(rx_sym_ready_o));
   always @(posedge clk_i) begin
      if (!rst_i && tx_sym_valid_o === 1'b1 && tx_sym_ready_i === 1'b1) symq.push_back(tx_sym_o);
      if (!rst_i && rx_valid_o === 1'b1 && rx_ready_i === 1'b1) bitq.push_back(rx_bit_o);
   end
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      symq.delete();
      bitq.delete();
      @(posedge clk_i);
   endtask
   task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
      check(n == 2, "ack latency");
   endtask
   task automatic run(input logic [3:0] cfg, input logic inv, input logic [31:0] pat, input int skip);
      logic lvl, d;
      logic exp[$];
      int ones;
      logic [radio_bitstream_encoder_pkg::SHAPE_LEN-1:0] sr;
      lvl = 1'b0;
      ones = 0;
      sr = radio_bitstream_encoder_pkg::SHAPE_SEED;
      flip <= inv;
      slow <= cfg[0];
      do_reset();
      wb(1'b1, 32'h0, {28'h0, cfg});
      fork
         begin
            for (int i = 0; i < 32; i++) begin
               tx_bit_i <= pat[i];
               tx_valid_i <= 1'b1;
               do @(posedge clk_i); while (tx_ready_o !== 1'b1);
            end
            tx_valid_i <= 1'b0;
         end
         while (bitq.size() < 32) begin
            @(posedge clk_i);
            rx_ready_i <= ($time / 20) % 3 != 0;
         end
      join
      rx_ready_i <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         d = pat[i];
         if (cfg[3]) begin
            d = d ^ sr[radio_bitstream_encoder_pkg::SHAPE_TAP_A]
                  ^ sr[radio_bitstream_encoder_pkg::SHAPE_TAP_B];
            sr = {sr[radio_bitstream_encoder_pkg::SHAPE_LEN-2:0], d};
         end
         if (cfg[1]) begin
            lvl = lvl ^ d;
            d = lvl;
         end
         exp.push_back(d ^ cfg[0]);
         if (cfg[2]) exp.push_back(!(d ^ cfg[0]));
      end
      check(symq.size() == exp.size(), "symbol count");
      for (int i = 0; i < symq.size(); i++) ones += (symq[i] === 1'b1);
      for (int i = 0; i < exp.size(); i++) check(symq[i] === exp[i], "line symbol");
      if (cfg == 4'h8 && pat == 32'h0) check(ones > 0 && ones < 32, "shaped spectrum");
      for (int i = skip; i < 32; i++) check(bitq[i] === pat[i], "rx data");
   endtask
   task automatic test_registers();
      do_reset();
      wb(1'b0, 32'h0, 32'h0);
      check(rd === {28'h0, radio_bitstream_encoder_pkg::CFG_RESET}, "cfg reset");
      wb(1'b1, 32'h0, 32'hFFFF_FFFF);
      wb(1'b1, 32'h100, 32'h0);
      wb(1'b0, 32'h0, 32'h0);
      check(rd === 32'h0000_000F, "cfg readback");
      wb(1'b0, 32'h100, 32'h0);
      check(rd === 32'h0, "unmapped read");
      $display("test_registers done");
   endtask
   task automatic test_buffer();
      int taken;
      taken = 0;
      stall <= 1'b1;
      do_reset();
      tx_valid_i <= 1'b1;
      repeat (6) begin
         @(posedge clk_i);
         taken += (tx_ready_o === 1'b1);
      end
      tx_valid_i <= 1'b0;
      check(taken == 2, "buffer depth");
      wb(1'b0, 32'h8, 32'h0);
      check(rd === 32'h2, "tx count");
      wb(1'b0, 32'h4, 32'h0);
      check(rd[0] === 1'b1, "tx pending");
      stall <= 1'b0;
      for (int n = 0; n < 20 && tx_sym_valid_o !== 1'b0; n++) @(posedge clk_i);
      wb(1'b0, 32'h4, 32'h0);
      check(rd[0] === 1'b0, "tx drained");
      $display("test_buffer done");
   endtask
   task automatic test_status();
      stall <= 1'b1;
      do_reset();
      tx_bit_i <= 1'b1;
      tx_valid_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      tx_valid_i <= 1'b0;
      // Two equal plain symbols wait in the buffer, then arrive as one Manchester pair
      wb(1'b1, 32'h0, 32'h4);
      stall <= 1'b0;
      repeat (8) @(posedge clk_i);
      wb(1'b0, 32'h4, 32'h0);
      check(rd[4:2] === 3'h1, "manchester violation");
      wb(1'b0, 32'hC, 32'h0);
      check(rd === 32'h1, "rx count");
      wb(1'b1, 32'h4, 32'h4);
      wb(1'b0, 32'h4, 32'h0);
      check(rd[2] === 1'b0, "violation cleared");
      $display("test_status done");
   endtask
   task automatic test_codes();
      run(4'h0, 1'b0, PAT, 0);
      run(4'h1, 1'b0, PAT, 0);
      run(4'h2, 1'b0, PAT, 0);
      run(4'h4, 1'b0, PAT, 0);
      run(4'h5, 1'b0, PAT, 0);
      $display("test_codes done");
   endtask
   task automatic test_flip_shape();
      run(4'h2, 1'b1, PAT, 1);
      run(4'h8, 1'b0, 32'h0, 0);
      run(4'h8, 1'b0, PAT, 17);
      run(4'hF, 1'b1, PAT, 18);
      $display("test_flip_shape done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      test_registers();
      test_buffer();
      test_status();
      test_codes();
      test_flip_shape();
      tally_and_finish();
   end
   initial begin
      #400_000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
